// [spl_defs.vh]
`ifndef SPL_DEFS_VH
`define SPL_DEFS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SPL_CTRL_ADDR     12'h000
`define SPL_STATUS_ADDR   12'h004
`define SPL_CTRL_RESET    7'h00

// ctrl fields
`define SPL_C_INIT        0
`define SPL_C_PARTIAL     1
`define SPL_C_SLUMBER     2
`define SPL_C_NEAR_LB     3
`define SPL_C_FAR_LB      4
`define SPL_C_RATE_LO     5
`define SPL_C_RATE_HI     6

// rate select encoding
`define SPL_RATE_AUTO0    2'h0
`define SPL_RATE_GEN1     2'h1
`define SPL_RATE_GEN2     2'h2

// ----------------------------------------------------------------
// ten-bit symbols
// ----------------------------------------------------------------
`define SPL_K28_5_NEG     10'h0FA
`define SPL_K28_5_POS     10'h305
`define SPL_D10_2         10'h155
`define SPL_D27_3_NEG     10'h0E4
`define SPL_D27_3_POS     10'h31B

// ----------------------------------------------------------------
// timing in sys_clk cycles; SPL_OOB_BURSTS and SPL_OOB_DET_N count bursts, SPL_SYNC_LOSS counts words
// ----------------------------------------------------------------
`define SPL_DIV_GEN1      4'h8
`define SPL_DIV_GEN2      4'h4
`define SPL_OOB_BURST     8'h20
`define SPL_OOB_GAP_LONG  8'h60
`define SPL_OOB_BURSTS    3'h6
`define SPL_GAP_S_MIN     8'h18
`define SPL_GAP_S_MAX     8'h28
`define SPL_GAP_L_MIN     8'h50
`define SPL_GAP_L_MAX     8'h70
`define SPL_OOB_DET_N     3'h4
`define SPL_ALIGN_TMO     16'h2000
`define SPL_SYNC_LOSS     8'h40

`endif

// [spl_line_peer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "spl_defs.vh"
module spl_line_peer (
	input  wire logic clk_in,
	output var  logic line_out,
	output var  logic squelch_out
);
	// ----------------------------------------------------------------
	// far end of the cable
	// ----------------------------------------------------------------
	initial begin
		line_out = 1'b0;
		squelch_out = 1'b1;
	end
	// line never holds a level, so a stale bit cannot pass for data
	always @(posedge clk_in) begin
		line_out <= ~line_out;
	end
	// out-of-band sequence: n bursts, each followed by a quiet gap
	task automatic oob(input int gap, input int n);
		repeat (n) begin
			squelch_out <= 1'b0;
			repeat (`SPL_OOB_BURST) @(posedge clk_in);
			squelch_out <= 1'b1;
			repeat (gap) @(posedge clk_in);
		end
	endtask
endmodule
`default_nettype wire

// [spl_phy_link.v]
// Overview of operation
// - init request resets control and starts sending COMRESET bursts.
// - link up only while receiver synchronized and transmitter sends valid signal.
// - deep-sleep request enters Slumber power state.
// - shallow-sleep request enters Partial power state.
// - near loopback feeds own transmit stream into receiver.
// - far loopback sends received stream back out the transmitter.
// - rate select picks automatic negotiation or a forced speed.
// - rate indication shows the speed in effect.
// - comma flag pulses when a K28.5 is received.
// - receive word strobe comes from recovered data timing.
// - host: init detect asserted while COMINIT is received.
// - device: same init detect asserted while COMRESET is received.
// - wake detect asserted while COMWAKE is received.
// - pattern source sends ALIGN primitives when needed.
// - received ALIGN primitives are consumed, not passed as data.
// - data extraction recovers bit timing from the received stream.
// - link layer supplies words; each is serialized and sent.
// - received stream is deserialized into words for the link layer.
// - reference clock runs control logic and sets transmit rate.
// - internal transmit bit tick sets the serial bit rate.
// - far retimed loopback held until COMRESET or COMINIT received; here init detect clears it only once the far loopback control bit is cleared.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spl_defs.vh"

module spl_phy_link #(
	parameter        IS_HOST   = 0,
	parameter [15:0] ALIGN_TMO = `SPL_ALIGN_TMO
) (
	input  wire        sys_clk_in,
	input  wire        rst_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output reg         pready_out,
	output reg  [31:0] prdata_out,
	output reg         pslverr_out,
	input  wire [9:0]  tx_parallel_word_in,
	input  wire        tx_valid_in,
	output reg         tx_ready_out,
	output reg  [9:0]  rx_parallel_word_out,
	output reg         rx_word_strobe_out,
	output reg         comma_out,
	output reg         link_up_indication_out,
	output reg         rate_indication_out,
	output reg         oob_init_detect_out,
	output reg         oob_wake_detect_out,
	input  wire        rx_line_in,
	input  wire        rx_squelch_in,
	output reg         tx_line_out,
	output reg         tx_idle_out
);

	localparam [2:0] ST_COMRESET = 3'h0;
	localparam [2:0] ST_ALIGN    = 3'h1;
	localparam [2:0] ST_READY    = 3'h2;
	localparam [2:0] ST_PARTIAL  = 3'h3;
	localparam [2:0] ST_SLUMBER  = 3'h4;
	localparam [2:0] ST_FARLB    = 3'h5;

	function is_comma;
		input [9:0] s;
		begin
			is_comma = (s == `SPL_K28_5_NEG) || (s == `SPL_K28_5_POS);
		end
	endfunction

	function [9:0] align_sym;
		input [1:0] i;
		begin
			case (i)
				2'h0:    align_sym = `SPL_K28_5_NEG;
				2'h3:    align_sym = `SPL_D27_3_POS;
				default: align_sym = `SPL_D10_2;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	reg  [6:0] ctrl;
	reg  [2:0] state;
	reg        rx_sync;
	reg        far_lb_active;
	wire       apb_acc  = psel_in & penable_in & ~pready_out;
	wire       apb_done = psel_in & penable_in & pready_out;
	wire       hit_ctrl = paddr_in == `SPL_CTRL_ADDR;
	wire       hit_stat = paddr_in == `SPL_STATUS_ADDR;

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			ctrl        <= `SPL_CTRL_RESET;
			pready_out  <= 1'b0;
			prdata_out  <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= apb_acc;
			pslverr_out <= apb_acc & ~hit_ctrl & ~hit_stat;
			// write lands on the completing edge
			if (apb_done && pwrite_in && hit_ctrl)
				ctrl <= pwdata_in[6:0];
			if (apb_acc && !pwrite_in && hit_ctrl)
				prdata_out <= {25'h0000000, ctrl};
			else if (apb_acc && !pwrite_in && hit_stat)
				prdata_out <= {23'h000000, rate_indication_out, state, far_lb_active,
					oob_wake_detect_out, oob_init_detect_out, rx_sync, link_up_indication_out};
			else
				prdata_out <= 32'h0000_0000;
		end
	end

	wire [1:0] rate_sel = ctrl[`SPL_C_RATE_HI:`SPL_C_RATE_LO];

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	reg [1:0] line_sync;
	reg [1:0] sq_sync;

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			line_sync <= 2'h0;
			sq_sync   <= 2'h3;
		end else begin
			line_sync <= {line_sync[0], rx_line_in};
			sq_sync   <= {sq_sync[0], rx_squelch_in};
		end
	end

	wire rx_bit_raw = line_sync[1];
	// near loopback: receiver hears own transmitter, idle included
	wire rx_quiet   = ctrl[`SPL_C_NEAR_LB] ? tx_idle_out : sq_sync[1];

	// ----------------------------------------------------------------
	// rate and bit timing
	// ----------------------------------------------------------------
	reg  [3:0] tx_div;
	wire [3:0] div = rate_indication_out ? `SPL_DIV_GEN2 : `SPL_DIV_GEN1;
	wire       tx_tick = tx_div == div - 4'h1;

	always @(posedge sys_clk_in) begin
		if (rst_in || tx_tick)
			tx_div <= 4'h0;
		else
			tx_div <= tx_div + 4'h1;
	end

	// ----------------------------------------------------------------
	// data extraction and deserializer
	// ----------------------------------------------------------------
	wire       rx_bit = ctrl[`SPL_C_NEAR_LB] ? tx_line_out : rx_bit_raw;
	reg        rx_prev;
	reg  [3:0] rx_phase;
	reg  [9:0] rx_sh;
	reg  [3:0] rx_cnt;
	wire       rx_samp = rx_phase == {1'b0, div[3:1]};
	wire [9:0] sh_n    = {rx_sh[8:0], rx_bit};
	wire       word_done = rx_samp & (is_comma(sh_n) | rx_cnt == 4'h9);

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			rx_prev  <= 1'b0;
			rx_phase <= 4'h0;
			rx_sh    <= 10'h000;
			rx_cnt   <= 4'h0;
		end else begin
			rx_prev <= rx_bit;
			if (rx_bit != rx_prev || rx_phase == div - 4'h1)
				rx_phase <= 4'h0;
			else
				rx_phase <= rx_phase + 4'h1;
			if (rx_samp) begin
				rx_sh  <= sh_n;
				rx_cnt <= word_done ? 4'h0 : rx_cnt + 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// align detect and word pipeline
	// ----------------------------------------------------------------
	reg  [1:0] al_idx;
	reg  [9:0] pw0, pw1, pw2;
	reg  [2:0] pv;
	reg  [7:0] no_comma;
	wire       w_k  = is_comma(sh_n);
	wire       w_d10 = sh_n == `SPL_D10_2;
	wire       w_d27 = sh_n == `SPL_D27_3_NEG || sh_n == `SPL_D27_3_POS;
	wire       al_found = al_idx == 2'h3 && w_d27;

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			al_idx <= 2'h0;
			pv     <= 3'h0;
			pw0    <= 10'h000;
			pw1    <= 10'h000;
			pw2    <= 10'h000;
			rx_parallel_word_out <= 10'h000;
			rx_word_strobe_out   <= 1'b0;
			comma_out <= 1'b0;
		end else begin
			rx_word_strobe_out <= 1'b0;
			comma_out <= word_done & w_k;
			if (word_done) begin
				if (w_k)
					al_idx <= 2'h1;
				else if ((al_idx == 2'h1 || al_idx == 2'h2) && w_d10)
					al_idx <= al_idx + 2'h1;
				else
					al_idx <= 2'h0;
				if (al_found) begin
					pv <= 3'h0;
				end else begin
					rx_parallel_word_out <= pw2;
					rx_word_strobe_out   <= pv[2];
					pw2 <= pw1;
					pw1 <= pw0;
					pw0 <= sh_n;
					pv  <= {pv[1:0], 1'b1};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// receive sync
	// ----------------------------------------------------------------
	always @(posedge sys_clk_in) begin
		if (rst_in || state == ST_COMRESET || rx_quiet) begin
			rx_sync  <= 1'b0;
			no_comma <= 8'h00;
		end else if (word_done) begin
			if (al_found) begin
				rx_sync  <= 1'b1;
				no_comma <= 8'h00;
			end else if (w_k) begin
				no_comma <= 8'h00;
			end else if (no_comma == `SPL_SYNC_LOSS) begin
				rx_sync <= 1'b0;
			end else begin
				no_comma <= no_comma + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// out-of-band detector
	// ----------------------------------------------------------------
	reg        quiet_d;
	reg  [7:0] gap;
	reg  [2:0] long_run, short_run;
	wire       burst_start = quiet_d & ~rx_quiet;
	wire       g_long  = gap >= `SPL_GAP_L_MIN && gap <= `SPL_GAP_L_MAX;
	wire       g_short = gap >= `SPL_GAP_S_MIN && gap <= `SPL_GAP_S_MAX;
	wire       gap_over = gap > `SPL_GAP_L_MAX;

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			quiet_d   <= 1'b1;
			gap       <= 8'h00;
			long_run  <= 3'h0;
			short_run <= 3'h0;
			oob_init_detect_out <= 1'b0;
			oob_wake_detect_out <= 1'b0;
		end else begin
			quiet_d <= rx_quiet;
			if (!rx_quiet)
				gap <= 8'h00;
			else if (!gap_over)
				gap <= gap + 8'h01;
			if (burst_start) begin
				long_run  <= g_long ? (long_run == 3'h7 ? long_run : long_run + 3'h1) : 3'h0;
				short_run <= g_short ? (short_run == 3'h7 ? short_run : short_run + 3'h1) : 3'h0;
			end else if (gap_over) begin
				long_run  <= 3'h0;
				short_run <= 3'h0;
			end
			// host sees COMINIT, device sees COMRESET on the same output
			oob_init_detect_out <= long_run >= `SPL_OOB_DET_N && !gap_over;
			oob_wake_detect_out <= short_run >= `SPL_OOB_DET_N && gap <= `SPL_GAP_S_MAX;
		end
	end

	// ----------------------------------------------------------------
	// control state machine
	// ----------------------------------------------------------------
	reg  [7:0]  oob_cnt;
	reg  [2:0]  oob_num;
	reg         oob_gap;
	reg  [15:0] tmo;
	reg  [2:0]  next_state;

	always @* begin
		next_state = state;
		case (state)
			ST_COMRESET:
				if (oob_num == `SPL_OOB_BURSTS)
					next_state = ST_ALIGN;
			ST_ALIGN:
				if (rx_sync)
					next_state = ST_READY;
			ST_READY:
				if (ctrl[`SPL_C_SLUMBER])
					next_state = ST_SLUMBER;
				else if (ctrl[`SPL_C_PARTIAL])
					next_state = ST_PARTIAL;
				else if (far_lb_active)
					next_state = ST_FARLB;
				else if (oob_init_detect_out)
					next_state = ST_ALIGN;
			ST_PARTIAL:
				if (!ctrl[`SPL_C_PARTIAL] || oob_wake_detect_out)
					next_state = ST_ALIGN;
			ST_SLUMBER:
				if (!ctrl[`SPL_C_SLUMBER] || oob_wake_detect_out)
					next_state = ST_ALIGN;
			ST_FARLB:
				if (!far_lb_active)
					next_state = ST_ALIGN;
			default:
				next_state = ST_COMRESET;
		endcase
		if (ctrl[`SPL_C_INIT])
			next_state = ST_COMRESET;
	end

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			state   <= ST_COMRESET;
			oob_cnt <= 8'h00;
			oob_num <= 3'h0;
			oob_gap <= 1'b0;
			tmo     <= 16'h0000;
			far_lb_active <= 1'b0;
			rate_indication_out <= 1'b0;
		end else begin
			state <= next_state;
			// set wins over the out-of-band clear
			if (ctrl[`SPL_C_FAR_LB])
				far_lb_active <= 1'b1;
			else if (oob_init_detect_out)
				far_lb_active <= 1'b0;
			if (state != ST_COMRESET || ctrl[`SPL_C_INIT]) begin
				oob_cnt <= 8'h00;
				oob_num <= 3'h0;
				oob_gap <= 1'b0;
			end else if (oob_cnt == (oob_gap ? `SPL_OOB_GAP_LONG : `SPL_OOB_BURST)) begin
				oob_cnt <= 8'h00;
				oob_gap <= ~oob_gap;
				if (oob_gap)
					oob_num <= oob_num + 3'h1;
			end else begin
				oob_cnt <= oob_cnt + 8'h01;
			end
			if (state != ST_ALIGN || tmo == ALIGN_TMO)
				tmo <= 16'h0000;
			else
				tmo <= tmo + 16'h0001;
			case (rate_sel)
				`SPL_RATE_GEN1: rate_indication_out <= 1'b0;
				`SPL_RATE_GEN2: rate_indication_out <= 1'b1;
				default:
					if (state == ST_ALIGN && tmo == ALIGN_TMO)
						rate_indication_out <= ~rate_indication_out;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// transmit path
	// ----------------------------------------------------------------
	reg  [9:0] tx_sh;
	reg  [3:0] tx_cnt;
	reg  [1:0] tx_al;
	wire       tx_load = tx_tick && tx_cnt == 4'h0;
	// data only between whole ALIGN primitives, so the far detector never sees a torn one
	wire       take = tx_load && state == ST_READY && rx_sync && tx_valid_in && !tx_ready_out &&
		tx_al == 2'h0;
	wire       quiet_tx = (state == ST_COMRESET && oob_gap) ||
		state == ST_PARTIAL || state == ST_SLUMBER;

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			tx_sh  <= 10'h000;
			tx_cnt <= 4'h0;
			tx_al  <= 2'h0;
			tx_ready_out <= 1'b0;
			tx_line_out  <= 1'b0;
			tx_idle_out  <= 1'b1;
		end else begin
			tx_ready_out <= take;
			if (tx_load) begin
				tx_cnt <= 4'h9;
				if (take) begin
					tx_sh <= tx_parallel_word_in;
				end else begin
					tx_sh <= align_sym(tx_al);
					tx_al <= tx_al + 2'h1;
				end
			end else if (tx_tick) begin
				tx_cnt <= tx_cnt - 4'h1;
				tx_sh  <= {tx_sh[8:0], 1'b0};
			end
			if (state == ST_FARLB) begin
				tx_line_out <= rx_bit_raw;
				tx_idle_out <= rx_quiet;
			end else begin
				tx_line_out <= tx_sh[9];
				tx_idle_out <= quiet_tx;
			end
		end
	end

	// ----------------------------------------------------------------
	// link up
	// ----------------------------------------------------------------
	always @(posedge sys_clk_in) begin
		if (rst_in)
			link_up_indication_out <= 1'b0;
		else
			link_up_indication_out <= next_state == ST_READY && state == ST_READY &&
				rx_sync && !quiet_tx && !ctrl[`SPL_C_INIT];
	end

endmodule
`default_nettype wire

// [spl_phy_link_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "spl_defs.vh"
module spl_phy_link_assertions (
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic        pready_out,
	input wire logic        tx_valid_in,
	input wire logic        tx_ready_out,
	input wire logic        rx_word_strobe_out,
	input wire logic        comma_out,
	input wire logic        link_up_indication_out,
	input wire logic        rate_indication_out,
	input wire logic        oob_init_detect_out,
	input wire logic        tx_idle_out
);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	wire sleep_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == `SPL_CTRL_ADDR
		&& pwdata_in[`SPL_C_SLUMBER];
	a_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("apb answer late");
	a_apb_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready held");
	a_link_tx_valid: assert property (link_up_indication_out |-> !tx_idle_out)
		else $error("link up while line idle");
	a_link_oob_drop: assert property (oob_init_detect_out |-> ##[0:3] !link_up_indication_out)
		else $error("link kept over init detect");
	a_sleep_link_drop: assert property (sleep_wr |-> ##[1:4] !link_up_indication_out)
		else $error("link kept in slumber");
	a_rate_stable_up: assert property ($changed(rate_indication_out) |-> !link_up_indication_out)
		else $error("rate changed with link up");
	a_tx_word_spacing: assert property (tx_ready_out |=> !tx_ready_out [*8])
		else $error("tx words too close");
	a_tx_ready_cause: assert property (tx_ready_out |-> $past(tx_valid_in) && !tx_idle_out)
		else $error("tx ready without word");
	a_rx_word_spacing: assert property (rx_word_strobe_out |=> !rx_word_strobe_out [*8])
		else $error("rx strobes too close");
	a_comma_pulse: assert property (comma_out |=> !comma_out)
		else $error("comma held");
	c_link_up: cover property ($rose(link_up_indication_out));
	c_init_seen: cover property ($rose(oob_init_detect_out));
	c_tx_word: cover property (tx_ready_out);
endmodule
bind spl_phy_link spl_phy_link_assertions i_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.pready_out(pready_out), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
	.rx_word_strobe_out(rx_word_strobe_out), .comma_out(comma_out),
	.link_up_indication_out(link_up_indication_out), .rate_indication_out(rate_indication_out),
	.oob_init_detect_out(oob_init_detect_out), .tx_idle_out(tx_idle_out));
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "spl_defs.vh"
module testbench;
	// ----------------------------------------------------------------
	// bench
	// ----------------------------------------------------------------
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [9:0]  txw = 10'h000;
	logic        txv = 1'b0;
	wire         pready, pslverr, txr, strobe, comma, link, rate, initd, waked, rxl, sq, idle;
	wire  [31:0] prdata;
	wire  [9:0]  rxw;
	logic [31:0] rd;
	logic        err;
	logic [9:0]  got[$];
	int          n_comma = 0;
	int          n_fail = 0;
	int          n_tests = 0;
	always #2 clk = ~clk;
	spl_phy_link #(.IS_HOST(0), .ALIGN_TMO(16'd64)) i_dut (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
		.prdata_out(prdata), .pslverr_out(pslverr), .tx_parallel_word_in(txw), .tx_valid_in(txv),
		.tx_ready_out(txr), .rx_parallel_word_out(rxw), .rx_word_strobe_out(strobe), .comma_out(comma),
		.link_up_indication_out(link), .rate_indication_out(rate), .oob_init_detect_out(initd),
		.oob_wake_detect_out(waked), .rx_line_in(rxl), .rx_squelch_in(sq), .tx_line_out(), .tx_idle_out(idle));
	spl_line_peer i_peer (.clk_in(clk), .line_out(rxl), .squelch_out(sq));
	always @(posedge clk) begin
		if (strobe === 1'b1)
			got.push_back(rxw);
		if (comma === 1'b1)
			n_comma++;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		#200000;
		n_fail++;
		test_done();
	end
	initial begin
		int          i, j, k, t;
		logic [9:0]  sent[8];
		logic        r0;
		k = $urandom(92);
		repeat (5) @(posedge clk);
		chk({link, initd, waked, txr, strobe, idle}, 6'b000001);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, `SPL_CTRL_ADDR, 0);
		chk(rd, 0);
		apb(1, 12'h0F0, 32'hFFFFFFFF);
		apb(0, 12'h0F0, 0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		for (i = 0; i < 4; i++) begin
			k = $urandom & 32'h78;
			apb(1, `SPL_CTRL_ADDR, k);
			apb(0, `SPL_CTRL_ADDR, 0);
			chk(rd, k);
		end
		for (i = 1; i < 3; i++) begin
			apb(1, `SPL_CTRL_ADDR, i << `SPL_C_RATE_LO);
			repeat (4) @(posedge clk);
			chk(rate, i == 2);
		end
		apb(1, `SPL_CTRL_ADDR, 32'h01);
		apb(1, `SPL_CTRL_ADDR, 0);
		for (t = 0; t < 400 && idle !== 1'b1; t++) @(posedge clk);
		for (t = 0; t < 400 && idle !== 1'b0; t++) @(posedge clk);
		for (t = 0; t < 200 && idle !== 1'b1; t++) @(posedge clk);
		chk(t >= 31 && t <= 33, 1);
		r0 = rate;
		for (t = 0; t < 3000 && rate === r0; t++) @(posedge clk);
		chk(rate, !r0);
		apb(1, `SPL_CTRL_ADDR, 32'h10);
		apb(1, `SPL_CTRL_ADDR, 0);
		apb(0, `SPL_STATUS_ADDR, 0);
		chk(rd[4], 1);
		i_peer.oob(8'h60, 6);
		chk({initd, waked}, 2'b10);
		apb(0, `SPL_STATUS_ADDR, 0);
		chk(rd[4], 0);
		repeat (200) @(posedge clk);
		chk(initd, 0);
		i_peer.oob(8'h20, 6);
		chk({initd, waked}, 2'b01);
		i_peer.oob(8'h40, 6);
		chk({initd, waked}, 2'b00);
		apb(1, `SPL_CTRL_ADDR, 32'h28);
		for (t = 0; t < 5000 && link !== 1'b1; t++) @(posedge clk);
		chk(link, 1);
		got.delete();
		for (i = 0; i < 8; i++) begin
			sent[i] = 10'h2AA ^ 10'($urandom & 32'h0C3);
			txw <= sent[i];
			txv <= 1'b1;
			@(posedge clk);
			for (t = 0; t < 500 && txr !== 1'b1; t++) @(posedge clk);
			chk(txr, 1);
		end
		txv <= 1'b0;
		repeat (600) @(posedge clk);
		for (i = 0; i < 4; i++) begin
			k = 0;
			foreach (got[j]) if (got[j] === sent[i]) k = 1;
			chk(k, 1);
		end
		k = 0;
		foreach (got[j]) if (got[j] === `SPL_K28_5_NEG || got[j] === `SPL_K28_5_POS) k++;
		chk(k, 0);
		chk(n_comma > 0, 1);
		for (j = 1; j < 3; j++) begin
			apb(1, `SPL_CTRL_ADDR, 32'h28);
			for (t = 0; t < 5000 && link !== 1'b1; t++) @(posedge clk);
			chk(link, 1);
			apb(1, `SPL_CTRL_ADDR, 32'h28 | (1 << j));
			apb(0, `SPL_STATUS_ADDR, 0);
			chk(rd[7:5], j == 2 ? 3'h4 : 3'h3);
			chk(link, 0);
		end
		test_done();
	end
endmodule
`default_nettype wire
